// ---- hw/mf_pkg.sv ----
// Purpose: shared constants, types and the tone-pair table of the MF digit receiver
// Assumes: 8 kHz mu-law samples, energy evaluated over blocks of samples
// Notes: times are kept in ms and converted to whole analysis blocks
// Behaviour
// R1: input samples are mu-law only; no other companding law is handled.
// R2: digits 0-9 decode from pairs of 700, 900, 1100, 1300, 1500 Hz.
// R3: 1700 Hz plus one tone gives start or one of four end-of-pulsing signals.
// R4: tone counts as present within 1.5 percent plus 5 Hz of nominal.
// R5: accept components from 0 to -25 dBm0, reject at -35 dBm0 and below.
// R6: accept pairs whose two component levels differ by up to 6 dB.
// R7: digits and end signals validate above 30 ms, discard below 10 ms.
// R8: start signal validates above 55 ms, may above 30 ms, rejects below 10 ms.
// R9: dropouts shorter than 10 ms are bridged into one continuous signal.
// R10: components may start or stop up to 4 ms apart.
// R11: pairs whose components coincide under 10 ms are rejected.
// R12: silence over 25 ms separates signals so the next counts separately.
// R13: sustain at least 10 signals per second without losing digits.
// R14: nothing reported before a valid start signal, which then unlocks.
// R15: unlocked reports digits until any end variant, then locks again.
// R16: further start signals are ignored while unlocked.
// R17: more than two valid components at once reports nothing.
// R18: intermodulation 28 dB below the components causes no false detection.
// R19: each accepted signal reported once as 4-bit code with one-cycle strobe.
// R20: reset locks, clears duration counters and drops any pending report.
package mf_pkg;
  localparam int SAMPLE_W = 8;
  localparam int LIN_W = 16;
  localparam int NUM_TONES = 6;
  localparam int COEF_W = 16;
  localparam int COEF_FRAC = 14;
  localparam int ACC_W = 28;
  localparam int ENERGY_SHIFT = 10;
  localparam int ENERGY_W = 40;
  localparam int CODE_W = 4;
  localparam int CNT_W = 8;
  localparam int BLK_IDX_W = 6;
  localparam logic [LIN_W-1:0] MULAW_BIAS = 16'h0084;
  localparam int MULAW_MANT_SHIFT = 3;

  localparam int SAMPLE_PERIOD_US = 125;
  localparam int BLOCK_LEN = 40;
  localparam int BLOCK_US = BLOCK_LEN * SAMPLE_PERIOD_US;
  localparam int REJECT_MS = 10;
  localparam int KP_MAY_MS = 30;
  localparam int BRIDGE_MS = 10;
  localparam int SKEW_MS = 4;
  localparam int GAP_MS = 25;
  // strictly beyond the reject time, so a 10 ms burst never reaches it
  localparam int MIN_BLK = REJECT_MS * 1000 / BLOCK_US + 1;
  localparam int KP_BLK = (KP_MAY_MS * 1000 + BLOCK_US - 1) / BLOCK_US;
  localparam int BRIDGE_BLK = BRIDGE_MS * 1000 / BLOCK_US;
  localparam int SKEW_BLK = (SKEW_MS * 1000 + BLOCK_US - 1) / BLOCK_US;
  localparam int GAP_BLK = (GAP_MS * 1000 + BLOCK_US - 1) / BLOCK_US;
  // 6 dB in power is a factor of four
  localparam int TWIST_SHIFT = 2;
  // near -29 dBm0 for a steady tone over one block: between accept and reject
  localparam logic [ENERGY_W-1:0] LEVEL_MIN_DEFAULT = 40'h0000000100;

  // 2*cos(2*pi*f/8000) in Q14 for 700, 900, 1100, 1300, 1500, 1700 Hz
  localparam logic signed [COEF_W-1:0] TONE_COEF [NUM_TONES] = '{
    16'h6D23, 16'h6155, 16'h5321, 16'h42E1, 16'h30FC, 16'h1DE1};

  localparam logic [CODE_W-1:0] CODE_START_OF_PULSING = 4'hA;
  localparam logic [CODE_W-1:0] CODE_END_OF_PULSING = 4'hB;
  localparam logic [CODE_W-1:0] CODE_END_OF_PULSING_PRIMED = 4'hC;
  localparam logic [CODE_W-1:0] CODE_END_OF_PULSING_DOUBLE_PRIMED = 4'hD;
  localparam logic [CODE_W-1:0] CODE_END_OF_PULSING_TRIPLE_PRIMED = 4'hE;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ON = 2'b01,
    S_DROP = 2'b10,
    S_GAP = 2'b11
  } sig_state_t;

  // mask bit 0 is 700 Hz up to bit 5 at 1700 Hz; result is {legal, code}
  function automatic logic [CODE_W:0] pair_lookup(input logic [NUM_TONES-1:0] mask);
    unique case (mask)
      6'h03: pair_lookup = {1'b1, 4'h1};
      6'h05: pair_lookup = {1'b1, 4'h2};
      6'h06: pair_lookup = {1'b1, 4'h3};
      6'h09: pair_lookup = {1'b1, 4'h4};
      6'h0A: pair_lookup = {1'b1, 4'h5};
      6'h0C: pair_lookup = {1'b1, 4'h6};
      6'h11: pair_lookup = {1'b1, 4'h7};
      6'h12: pair_lookup = {1'b1, 4'h8};
      6'h14: pair_lookup = {1'b1, 4'h9};
      6'h18: pair_lookup = {1'b1, 4'h0};
      6'h24: pair_lookup = {1'b1, CODE_START_OF_PULSING};
      6'h30: pair_lookup = {1'b1, CODE_END_OF_PULSING};
      6'h22: pair_lookup = {1'b1, CODE_END_OF_PULSING_PRIMED};
      6'h28: pair_lookup = {1'b1, CODE_END_OF_PULSING_DOUBLE_PRIMED};
      6'h21: pair_lookup = {1'b1, CODE_END_OF_PULSING_TRIPLE_PRIMED};
      default: pair_lookup = {1'b0, 4'h0};
    endcase
  endfunction : pair_lookup
endpackage : mf_pkg

// ---- hw/tone_if.sv ----
// Purpose: carries per-block tone energies from the filter bank to the decoder
// Assumes: done pulses for one cycle with all energies valid
// Notes: energies hold until the next done
`timescale 1ns/10ps
interface tone_if;
  logic [mf_pkg::ENERGY_W-1:0] energy [mf_pkg::NUM_TONES];
  logic done;
  modport src (output energy, output done);
  modport dst (input energy, input done);
endinterface : tone_if

// ---- hw/mulaw_expand.sv ----
// Purpose: mu-law byte to signed linear sample
// Assumes: byte arrives in transmitted (inverted) form
// Notes: purely combinational
`timescale 1ns/10ps
module mulaw_expand (
  input wire logic [mf_pkg::SAMPLE_W-1:0] code_in,
  output logic signed [mf_pkg::LIN_W-1:0] linear_out
);
  import mf_pkg::*;
  wire [SAMPLE_W-1:0] inv = ~code_in;
  wire [LIN_W-1:0] mant = {12'h000, inv[3:0]};
  wire [LIN_W-1:0] shifted = ((mant << MULAW_MANT_SHIFT) + MULAW_BIAS) << inv[6:4];
  wire [LIN_W-1:0] mag = shifted - MULAW_BIAS;
  // only the mu-law segment law is expanded, no other law
  assign linear_out = inv[7] ? -$signed(mag) : $signed(mag); // R1
endmodule : mulaw_expand

// ---- hw/goertzel_bank.sv ----
// Purpose: one Goertzel filter per MF tone, energy per block of samples
// Assumes: sample_valid_in pulses at least two cycles apart
// Notes: block length sets bandwidth and hence frequency tolerance
`timescale 1ns/10ps
module goertzel_bank #(
  parameter int BLOCK = mf_pkg::BLOCK_LEN
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic signed [mf_pkg::LIN_W-1:0] sample_in,
  input wire logic sample_valid_in,
  tone_if.src tones
);
  import mf_pkg::*;
  localparam int EIN_W = ACC_W - ENERGY_SHIFT;
  localparam logic [BLK_IDX_W-1:0] LAST_IDX = BLK_IDX_W'(BLOCK - 1);
  logic [BLK_IDX_W-1:0] idx_reg;
  logic calc_reg;
  logic done_reg;
  wire last_sample = sample_valid_in && (idx_reg == LAST_IDX);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idx_reg <= '0;
      calc_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      calc_reg <= last_sample;
      done_reg <= calc_reg;
      if (sample_valid_in) begin
        idx_reg <= last_sample ? '0 : idx_reg + 1'b1;
      end
    end
  end
  // energies land on the calc edge, so done trails it to flag fresh values
  assign tones.done = done_reg;

  // bin width of BLOCK samples covers the plus 1.5 percent plus 5 Hz band
  for (genvar t = 0; t < NUM_TONES; t++) begin : g_tone // R4
    logic signed [ACC_W-1:0] q1_reg;
    logic signed [ACC_W-1:0] q2_reg;
    logic [ENERGY_W-1:0] energy_reg;
    wire signed [ACC_W+COEF_W-1:0] fb = TONE_COEF[t] * q1_reg;
    wire signed [ACC_W-1:0] s_next = ACC_W'(sample_in) + ACC_W'(fb >>> COEF_FRAC) - q2_reg;
    wire signed [EIN_W-1:0] a = EIN_W'(q1_reg >>> ENERGY_SHIFT);
    wire signed [EIN_W-1:0] b = EIN_W'(q2_reg >>> ENERGY_SHIFT);
    wire signed [2*EIN_W+COEF_W-1:0] cab = TONE_COEF[t] * a * b;
    wire signed [ENERGY_W-1:0] e = ENERGY_W'(a * a) + ENERGY_W'(b * b)
                                   - ENERGY_W'(cab >>> COEF_FRAC);
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || calc_reg) begin
        q1_reg <= '0;
        q2_reg <= '0;
      end else if (sample_valid_in) begin
        q1_reg <= s_next;
        q2_reg <= q1_reg;
      end
    end
    always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
        energy_reg <= '0;
      end else if (calc_reg) begin
        energy_reg <= e[ENERGY_W-1] ? '0 : e;
      end
    end
    assign tones.energy[t] = energy_reg;
  end

  a_done_single: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    tones.done |=> !tones.done) else $error("block done longer than one cycle"); // R13
endmodule : goertzel_bank

// ---- hw/mf_digit_receiver.sv ----
// Purpose: MF tone-pair receiver that reports validated digits and signals
// Assumes: mu-law samples from logic on the same clock, one strobe per sample
// Notes: timing is measured in analysis blocks, so durations are quantised
`timescale 1ns/10ps
module mf_digit_receiver #(
  parameter logic [mf_pkg::ENERGY_W-1:0] LEVEL_MIN = mf_pkg::LEVEL_MIN_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [mf_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic [mf_pkg::CODE_W-1:0] digit_code_out,
  output logic digit_valid_out,
  output logic unlocked_out,
  output logic excess_out
);
  import mf_pkg::*;

  localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_BLK);
  localparam logic [CNT_W-1:0] KP_CNT = CNT_W'(KP_BLK);
  localparam logic [CNT_W-1:0] BRIDGE_CNT = CNT_W'(BRIDGE_BLK);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_BLK);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [2:0] PAIR_COUNT = 3'h2;

  logic signed [LIN_W-1:0] linear;
  tone_if tones ();

  mulaw_expand u_expand (
    .code_in(sample_in),
    .linear_out(linear)
  );

  goertzel_bank #(
    .BLOCK(BLOCK_LEN)
  ) u_bank (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .sample_in(linear),
    .sample_valid_in(sample_valid_in),
    .tones(tones)
  );

  // strongest component, used as the reference for twist
  wire [ENERGY_W-1:0] peak_chain [NUM_TONES+1];
  wire [2:0] count_chain [NUM_TONES+1];
  wire [NUM_TONES-1:0] comp_mask;
  wire [ENERGY_W-1:0] twist_floor = peak_chain[NUM_TONES] >> TWIST_SHIFT;
  assign peak_chain[0] = '0;
  assign count_chain[0] = '0;

  for (genvar t = 0; t < NUM_TONES; t++) begin : g_comp
    wire [ENERGY_W-1:0] e = tones.energy[t];
    assign peak_chain[t+1] = (e > peak_chain[t]) ? e : peak_chain[t];
    // absolute floor sits between the accept and reject levels
    wire loud = e >= LEVEL_MIN; // R5
    // anything over 6 dB below the peak, such as intermodulation, is not a component
    wire close = e >= twist_floor; // R6 R18
    assign comp_mask[t] = loud && close;
    assign count_chain[t+1] = count_chain[t] + {2'b00, comp_mask[t]};
  end

  wire [2:0] comp_count = count_chain[NUM_TONES];
  wire excess = comp_count > PAIR_COUNT;
  wire [CODE_W:0] lookup = pair_lookup(comp_mask); // R2 R3
  // three or more components never form a pair
  wire pair_ok = (comp_count == PAIR_COUNT) && lookup[CODE_W]; // R17
  wire [CODE_W-1:0] pair_code = lookup[CODE_W-1:0];
  wire blk = tones.done;

  sig_state_t state_reg;
  sig_state_t state_next;
  logic [CODE_W-1:0] code_reg;
  logic [CODE_W-1:0] code_next;
  logic [CNT_W-1:0] on_cnt_reg;
  logic [CNT_W-1:0] on_cnt_next;
  logic [CNT_W-1:0] off_cnt_reg;
  logic [CNT_W-1:0] off_cnt_next;
  logic reported_reg;
  logic reported_next;
  logic unlocked_reg;
  logic unlocked_next;
  logic [CODE_W-1:0] out_code_reg;
  logic [CODE_W-1:0] out_code_next;
  logic valid_reg;
  logic excess_reg;

  wire match = pair_ok && (pair_code == code_reg);
  wire [CNT_W-1:0] on_inc = (on_cnt_reg == CNT_MAX) ? on_cnt_reg : on_cnt_reg + 1'b1;
  wire [CNT_W-1:0] off_inc = (off_cnt_reg == CNT_MAX) ? off_cnt_reg : off_cnt_reg + 1'b1;
  wire is_start = code_reg == CODE_START_OF_PULSING;
  wire is_end = (code_reg == CODE_END_OF_PULSING)
                || (code_reg == CODE_END_OF_PULSING_PRIMED)
                || (code_reg == CODE_END_OF_PULSING_DOUBLE_PRIMED)
                || (code_reg == CODE_END_OF_PULSING_TRIPLE_PRIMED);
  // start signal needs the longer qualification, others beyond the reject time
  wire [CNT_W-1:0] need_cnt = is_start ? KP_CNT : MIN_CNT; // R7 R8 R11
  wire in_signal = (state_reg == S_ON) || (state_reg == S_DROP);
  wire fire = blk && in_signal && match && !reported_reg && (on_inc >= need_cnt);
  // locked passes only the start signal, unlocked passes all but start
  wire emit = fire && (unlocked_reg ? !is_start : is_start); // R14 R16

  // one block with a lone component is ignored in S_IDLE at the leading edge and is a short dropout at the trailing edge
  always_comb begin // R9 R10 R12 R13
    state_next = state_reg;
    code_next = code_reg;
    on_cnt_next = on_cnt_reg;
    off_cnt_next = off_cnt_reg;
    reported_next = reported_reg || fire;
    if (blk) begin
      unique case (state_reg)
        S_IDLE: begin
          if (pair_ok) begin
            state_next = S_ON;
            code_next = pair_code;
            on_cnt_next = CNT_W'(1);
            off_cnt_next = '0;
            reported_next = 1'b0;
          end
        end
        S_ON: begin
          if (match) begin
            on_cnt_next = on_inc;
          end else begin
            state_next = S_DROP;
            off_cnt_next = CNT_W'(1);
          end
        end
        S_DROP: begin
          if (match) begin
            state_next = S_ON;
            on_cnt_next = on_inc;
            off_cnt_next = '0;
          end else if (off_inc > BRIDGE_CNT) begin
            state_next = S_GAP;
            off_cnt_next = off_inc;
          end else begin
            off_cnt_next = off_inc;
          end
        end
        S_GAP: begin
          if (comp_count != 3'h0) begin
            off_cnt_next = '0;
          end else if (off_inc >= GAP_CNT) begin
            state_next = S_IDLE;
            off_cnt_next = '0;
          end else begin
            off_cnt_next = off_inc;
          end
        end
      endcase
    end
  end

  always_comb begin // R15
    unlocked_next = unlocked_reg;
    out_code_next = out_code_reg;
    if (emit) begin
      out_code_next = code_reg;
      unlocked_next = unlocked_reg ? !is_end : 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin // R20
      state_reg <= S_IDLE;
      code_reg <= '0;
      on_cnt_reg <= '0;
      off_cnt_reg <= '0;
      reported_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      on_cnt_reg <= on_cnt_next;
      off_cnt_reg <= off_cnt_next;
      reported_reg <= reported_next;
      unlocked_reg <= unlocked_next;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      out_code_reg <= '0;
      valid_reg <= 1'b0;
      excess_reg <= 1'b0;
    end else begin
      out_code_reg <= out_code_next;
      valid_reg <= emit; // R19
      excess_reg <= blk ? excess : excess_reg;
    end
  end

  assign digit_code_out = out_code_reg;
  assign digit_valid_out = valid_reg;
  assign unlocked_out = unlocked_reg;
  assign excess_out = excess_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_strobe_single: assert property ( // R19
    digit_valid_out |=> !digit_valid_out)
    else $error("report strobe longer than one cycle");

  a_locked_start_only: assert property ( // R14
    digit_valid_out && !$past(unlocked_reg) |-> digit_code_out == CODE_START_OF_PULSING)
    else $error("locked receiver reported something other than start");

  a_start_unlocks: assert property ( // R14
    digit_valid_out && digit_code_out == CODE_START_OF_PULSING |-> unlocked_reg)
    else $error("start report did not unlock");

  a_end_locks: assert property ( // R15
    digit_valid_out && digit_code_out >= CODE_END_OF_PULSING |-> !unlocked_reg)
    else $error("end variant report did not lock");

  a_start_ignored: assert property ( // R16
    digit_valid_out && $past(unlocked_reg) |-> digit_code_out != CODE_START_OF_PULSING)
    else $error("repeated start reported while unlocked");

  a_excess_silent: assert property ( // R17
    blk && excess |-> !fire)
    else $error("signal qualified with too many components");

  a_min_duration: assert property ( // R7
    fire && !is_start |-> on_cnt_reg >= MIN_CNT - 1'b1)
    else $error("short signal qualified");

  a_start_duration: assert property ( // R8
    fire && is_start |-> on_cnt_reg >= KP_CNT - 1'b1)
    else $error("short start signal qualified");

  a_bridge_limit: assert property ( // R9
    state_reg == S_DROP |-> off_cnt_reg <= BRIDGE_CNT)
    else $error("dropout bridged longer than allowed");

  a_gap_needed: assert property ( // R12
    $rose(state_reg == S_IDLE) |-> $past(off_cnt_reg) >= GAP_CNT - 1'b1)
    else $error("separation accepted without full silent gap");

  a_reset_clears: assert property (disable iff (1'b0) // R20
    !reset_n_in |=> !unlocked_out && !digit_valid_out && state_reg == S_IDLE)
    else $error("reset left receiver active");
endmodule : mf_digit_receiver

// ---- sim/trunk_model.sv ----
// Purpose: far-end trunk sending MF tone pairs as mu-law samples
// Assumes: samples come every SPACING clocks, far faster than real 8 kHz
// Notes: tone frequencies are relative to the sample rate, so the squeeze is harmless
`timescale 1ns/10ps
module trunk_model (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [5:0] tone_mask_in,
  input wire logic [5:0] low_mask_in,
  input int amp_in,
  input int detune_in,
  output logic [7:0] sample_out,
  output logic sample_valid_out
);
  localparam int SPACING = 4;
  int tick;
  int n;

  // mu-law in transmitted, inverted form
  function automatic logic [7:0] encode(input int lin);
    int mag;
    int ex;
    logic [7:0] s;
    s = (lin < 0) ? 8'h80 : 8'h00;
    mag = (lin < 0) ? -lin : lin;
    if (mag > 32635) mag = 32635;
    mag = mag + 132;
    ex = 7;
    while (ex > 0 && ((mag >> (ex + 7)) & 1) == 0) ex--;
    encode = ~(s | 8'(ex << 4) | 8'((mag >> (ex + 3)) & 15));
  endfunction : encode

  // bit k of the mask is 700 + 200*k Hz; low mask bits play at 0.6 amplitude
  function automatic int synth(input int idx);
    real acc;
    real a;
    real f;
    int k;
    acc = 0.0;
    for (k = 0; k < 6; k++) begin
      if (tone_mask_in[k]) begin
        a = low_mask_in[k] ? amp_in * 0.6 : amp_in * 1.0;
        f = (700.0 + 200.0 * k) * (1000 + detune_in) / 1000.0;
        acc = acc + a * $sin(6.283185307 * f * idx / 8000.0);
      end
    end
    synth = int'(acc);
  endfunction : synth

  always @(negedge core_clk_in) begin
    if (reset_n_in !== 1'b1) begin
      tick <= 0;
      n <= 0;
      sample_valid_out <= 1'b0;
      sample_out <= 8'hFF;
    end else if (tick == SPACING - 1) begin
      tick <= 0;
      n <= n + 1;
      sample_valid_out <= 1'b1;
      sample_out <= encode(synth(n));
    end else begin
      tick <= tick + 1;
      sample_valid_out <= 1'b0;
      // idle data toggles so a stale byte is never mistaken for a sample
      sample_out <= ~sample_out;
    end
  end
endmodule : trunk_model

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the MF digit receiver
// Assumes: tone switches land on analysis block boundaries
// Notes: reports are collected at every clock and judged after each signal
`timescale 1ns/10ps
module tb_top;
  import mf_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [5:0] tone_mask = 6'h00;
  logic [5:0] low_mask = 6'h00;
  int amp = 8000;
  int detune = 0;
  logic [SAMPLE_W-1:0] sample;
  logic sample_valid;
  logic [CODE_W-1:0] digit_code;
  logic digit_valid;
  logic unlocked;
  logic excess;
  logic [CODE_W-1:0] seen [$];
  logic excess_seen = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  logic [5:0] dmask [10] = '{6'h03, 6'h05, 6'h06, 6'h09, 6'h0A, 6'h0C, 6'h11, 6'h12, 6'h14, 6'h18};
  logic [CODE_W-1:0] dcode [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
  logic [5:0] emask [4] = '{6'h30, 6'h22, 6'h28, 6'h21};

  always #12.5 core_clk_in = ~core_clk_in;

  trunk_model partner (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .tone_mask_in(tone_mask), .low_mask_in(low_mask), .amp_in(amp), .detune_in(detune),
    .sample_out(sample), .sample_valid_out(sample_valid));

  mf_digit_receiver uut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .sample_in(sample), .sample_valid_in(sample_valid), .digit_code_out(digit_code),
    .digit_valid_out(digit_valid), .unlocked_out(unlocked), .excess_out(excess));

  // sampled mid-cycle, where registered outputs have settled
  always @(negedge core_clk_in) begin
    if (digit_valid === 1'b1) seen.push_back(digit_code);
    if (excess === 1'b1) excess_seen = 1'b1;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_code

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_num(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_num

  task automatic do_reset;
    reset_n_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in);
    reset_n_in <= 1'b1;
  endtask : do_reset

  // play a tone set for whole blocks, counting the samples actually taken
  task automatic play(input logic [5:0] mask, input int blocks);
    int cnt;
    int guard;
    cnt = 0;
    @(negedge core_clk_in);
    tone_mask <= mask;
    for (guard = 0; cnt < blocks * BLOCK_LEN; guard++) begin
      if (guard > blocks * BLOCK_LEN * 8 + 16) begin
        bad_count++;
        conclude();
      end
      @(posedge core_clk_in);
      if (sample_valid === 1'b1) cnt++;
    end
  endtask : play

  // one signal then enough silence to separate it from the next
  task automatic send(input logic [5:0] mask, input int on, input int n_exp,
                      input logic [CODE_W-1:0] code);
    seen.delete();
    play(mask, on);
    play(6'h00, 6);
    check_num(seen.size(), n_exp);
    if (n_exp > 0) check_code(seen[0], code);
  endtask : send

  task automatic s_locked;
    send(6'h0A, 6, 0, 4'h0);
    check_bit(unlocked, 1'b0);
  endtask : s_locked

  task automatic s_start;
    send(6'h24, 8, 1, CODE_START_OF_PULSING);
    check_bit(unlocked, 1'b1);
  endtask : s_start

  task automatic s_digits;
    for (int i = 0; i < 10; i++) begin
      send(dmask[i], 4, 1, dcode[i]);
    end
  endtask : s_digits

  task automatic s_short;
    send(6'h06, 2, 0, 4'h0);
  endtask : s_short

  task automatic s_bridge;
    seen.delete();
    // neither burst alone qualifies, so only a bridged dropout reports
    play(6'h06, 2);
    play(6'h00, 1);
    play(6'h06, 2);
    play(6'h00, 6);
    check_num(seen.size(), 1);
    check_code(seen[0], 4'h3);
  endtask : s_bridge

  task automatic s_excess;
    excess_seen = 1'b0;
    send(6'h07, 4, 0, 4'h0);
    check_bit(excess_seen, 1'b1);
  endtask : s_excess

  task automatic s_level;
    amp = 60;
    send(6'h0A, 4, 0, 4'h0);
    amp = 8000;
    low_mask = 6'h08;
    send(6'h0A, 4, 1, 4'h5);
    low_mask = 6'h00;
  endtask : s_level

  task automatic s_detune;
    detune = 12;
    send(6'h14, 4, 1, 4'h9);
    detune = -12;
    send(6'h18, 4, 1, 4'h0);
    detune = 0;
  endtask : s_detune

  task automatic s_restart;
    send(6'h24, 8, 0, 4'h0);
    check_bit(unlocked, 1'b1);
  endtask : s_restart

  // reset in mid-call must lock again and forget the call
  task automatic s_reset;
    do_reset();
    check_bit(unlocked, 1'b0);
    send(6'h0A, 4, 0, 4'h0);
  endtask : s_reset

  task automatic s_ends;
    for (int k = 0; k < 4; k++) begin
      send(6'h24, 7, 1, CODE_START_OF_PULSING);
      send(emask[k], 4, 1, CODE_END_OF_PULSING + 4'(k));
      check_bit(unlocked, 1'b0);
    end
  endtask : s_ends

  initial begin
    do_reset();
    s_locked();
    s_start();
    s_digits();
    s_short();
    s_bridge();
    s_excess();
    s_level();
    s_detune();
    s_restart();
    s_reset();
    s_ends();
    conclude();
  end
endmodule : tb_top
